//--- src/rail_defs.svh
`ifndef RAIL_DEFS_SVH
`define RAIL_DEFS_SVH

// ==========================================================
// register offsets
`define RAIL_ENABLE_OFS 8'h16
`define LOCKOUT_THRESHOLD_OFS 8'h18
`define SEQUENCE_SLOTS_FIRST_OFS 8'h19
`define SEQUENCE_SLOTS_SECOND_OFS 8'h1A

// ==========================================================
// field positions
`define SWITCH_ONE_ON_BIT 6
`define SWITCH_TWO_ON_BIT 5
`define BUCK_ONE_ON_BIT 4
`define BUCK_TWO_ON_BIT 3
`define BUCK_THREE_ON_BIT 2
`define LINREG_ONE_ON_BIT 1
`define LINREG_TWO_ON_BIT 0
`define SLOT_HI_LSB 4
`define SLOT_LO_LSB 0

// ==========================================================
// reset values
`define RAIL_ENABLE_RST 7'h00
`define LOCKOUT_THRESHOLD_RST 3'h3
`define BUCK_ONE_SLOT_RST 3'h1
`define BUCK_TWO_SLOT_RST_FIRST 3'h2
`define BUCK_TWO_SLOT_RST_OTHER 3'h5
`define BUCK_THREE_SLOT_RST_FIRST 3'h3
`define BUCK_THREE_SLOT_RST_OTHER 3'h5
`define LINREG_ONE_SLOT_RST_FIRST 4'hB
`define LINREG_ONE_SLOT_RST_OTHER 4'hF

// ==========================================================
// linear regulator one slot codes
`define LINREG_SLOT_LAST_PLAIN 4'h7
`define LINREG_SLOT_FOURTEEN 4'hE
`define LINREG_SLOT_WITH_SYSTEM 4'hF
`define SLOT_LAST 4'hF

// ==========================================================
// timing
`define CLK_PERIOD_NS 5
`define SLOT_TIME_NS 1000
`define SLOT_CYCLES (`SLOT_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- src/rail_pkg.sv
package rail_pkg;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // ==========================================================
  // rail switch outputs
  typedef struct packed {
    logic switch_one;
    logic switch_two;
    logic buck_one;
    logic buck_two;
    logic buck_three;
    logic linreg_one;
    logic linreg_two;
    logic system_power_rail;
  } rail_on_t;

  // ==========================================================
  // stepper states, gray along idle -> step -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP = 2'b01,
    ST_DONE = 2'b11
  } step_state_t;

endpackage : rail_pkg

//--- src/slot_stepper.sv
`include "rail_defs.svh"

module slot_stepper (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // power request
  input wire logic power_request_pin_i,
  // current slot
  output logic [3:0] slot_o
);

  rail_pkg::step_state_t state_q;
  logic [3:0] slot_q;
  logic [7:0] tick_q;
  localparam logic [7:0] TICK_LAST = 8'((`SLOT_CYCLES) - 1);

  // ==========================================================
  // slots step upward while the request is high
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !power_request_pin_i) begin
      state_q <= rail_pkg::ST_IDLE;
      slot_q <= 4'h0;
      tick_q <= 8'h00;
    end else begin
      case (state_q)
        rail_pkg::ST_IDLE: begin
          state_q <= rail_pkg::ST_STEP;
          slot_q <= 4'h1;
          tick_q <= 8'h00;
        end
        rail_pkg::ST_STEP: begin
          if (tick_q == TICK_LAST) begin
            tick_q <= 8'h00;
            if (slot_q == `SLOT_LAST) begin
              state_q <= rail_pkg::ST_DONE;
            end else begin
              slot_q <= slot_q + 4'h1;
            end
          end else begin
            tick_q <= tick_q + 8'h01;
          end
        end
        rail_pkg::ST_DONE: begin
          state_q <= rail_pkg::ST_DONE;
        end
        default: begin
          state_q <= rail_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign slot_o = slot_q;

  // ==========================================================
  // checks
  slot_ascend_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    power_request_pin_i && $past(power_request_pin_i) && slot_q != 4'h0
      && $past(slot_q) != 4'h0 |-> slot_q == $past(slot_q)
      || slot_q == $past(slot_q) + 4'h1)
    else $error("slot did not ascend by one");

  slot_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    !power_request_pin_i |=> slot_q == 4'h0)
    else $error("slot kept while request low");

endmodule : slot_stepper

//--- src/rail_enable_sequencer_regs.sv
`include "rail_defs.svh"

module rail_enable_sequencer_regs #(
  parameter bit FIRST_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register port
  input wire rail_pkg::reg_req_t reg_req_i,
  input wire logic write_unlocked_i,
  output logic [7:0] reg_rdata_o,
  // pins and rails
  input wire logic power_request_pin_i,
  output rail_pkg::rail_on_t rail_on_o,
  output logic [1:0] lockout_threshold_sel_o
);

  logic [6:0] rail_enable_q;
  logic [2:0] lockout_threshold_q;
  logic [2:0] buck_one_slot_q;
  logic [2:0] buck_two_slot_q;
  logic [2:0] buck_three_slot_q;
  logic [3:0] linreg_one_slot_q;
  logic [7:0] reg_rdata_q;
  rail_pkg::rail_on_t rail_on_q;
  rail_pkg::rail_on_t rail_on_d;
  logic [1:0] lockout_sel_q;
  logic [3:0] slot;
  logic wr_ok;
  logic seq_buck_one;
  logic seq_buck_two;
  logic seq_buck_three;
  logic seq_linreg_one;
  logic linreg_in_seq;

  // ==========================================================
  // slot stepper
  slot_stepper u_stepper (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .power_request_pin_i(power_request_pin_i),
    .slot_o(slot)
  );

  assign wr_ok = reg_req_i.wr && write_unlocked_i;

  // ==========================================================
  // rail enable register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rail_enable_q <= `RAIL_ENABLE_RST;
    end else if (wr_ok && reg_req_i.addr == `RAIL_ENABLE_OFS) begin
      rail_enable_q <= reg_req_i.wdata[6:0];
    end
  end

  // ==========================================================
  // lockout threshold register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lockout_threshold_q <= `LOCKOUT_THRESHOLD_RST;
    end else if (wr_ok && reg_req_i.addr == `LOCKOUT_THRESHOLD_OFS) begin
      lockout_threshold_q <= reg_req_i.wdata[2:0];
    end
  end

  // ==========================================================
  // sequencer slot registers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      buck_one_slot_q <= `BUCK_ONE_SLOT_RST;
      buck_two_slot_q <= FIRST_VARIANT ? `BUCK_TWO_SLOT_RST_FIRST
                                       : `BUCK_TWO_SLOT_RST_OTHER;
    end else if (wr_ok && reg_req_i.addr == `SEQUENCE_SLOTS_FIRST_OFS) begin
      buck_one_slot_q <= reg_req_i.wdata[`SLOT_HI_LSB +: 3];
      buck_two_slot_q <= reg_req_i.wdata[`SLOT_LO_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      buck_three_slot_q <= FIRST_VARIANT ? `BUCK_THREE_SLOT_RST_FIRST
                                         : `BUCK_THREE_SLOT_RST_OTHER;
      linreg_one_slot_q <= FIRST_VARIANT ? `LINREG_ONE_SLOT_RST_FIRST
                                         : `LINREG_ONE_SLOT_RST_OTHER;
    end else if (wr_ok && reg_req_i.addr == `SEQUENCE_SLOTS_SECOND_OFS) begin
      buck_three_slot_q <= reg_req_i.wdata[`SLOT_HI_LSB +: 3];
      linreg_one_slot_q <= reg_req_i.wdata[`SLOT_LO_LSB +: 4];
    end
  end

  // ==========================================================
  // read data, unmapped offsets read 0x00
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `RAIL_ENABLE_OFS: begin
          reg_rdata_q <= {1'b0, rail_enable_q};
        end
        `LOCKOUT_THRESHOLD_OFS: begin
          reg_rdata_q <= {5'h00, lockout_threshold_q};
        end
        `SEQUENCE_SLOTS_FIRST_OFS: begin
          reg_rdata_q <= {1'b0, buck_one_slot_q, 1'b0,
                          buck_two_slot_q};
        end
        `SEQUENCE_SLOTS_SECOND_OFS: begin
          reg_rdata_q <= {1'b0, buck_three_slot_q,
                          linreg_one_slot_q};
        end
        default: begin
          reg_rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // sequencer slot match, a reached slot keeps its rail on
  assign seq_buck_one = buck_one_slot_q != 3'h0
                        && slot >= {1'b0, buck_one_slot_q};
  assign seq_buck_two = buck_two_slot_q != 3'h0
                        && slot >= {1'b0, buck_two_slot_q};
  assign seq_buck_three = buck_three_slot_q != 3'h0
                          && slot >= {1'b0, buck_three_slot_q};
  assign linreg_in_seq = (linreg_one_slot_q != 4'h0
                          && linreg_one_slot_q <= `LINREG_SLOT_LAST_PLAIN)
                         || linreg_one_slot_q >= `LINREG_SLOT_FOURTEEN;
  assign seq_linreg_one = linreg_in_seq
                          && slot >= linreg_one_slot_q;

  // ==========================================================
  // rail drive
  always_comb begin
    rail_on_d.switch_one = power_request_pin_i
                           && rail_enable_q[`SWITCH_ONE_ON_BIT];
    rail_on_d.switch_two = power_request_pin_i
                           && rail_enable_q[`SWITCH_TWO_ON_BIT];
    rail_on_d.buck_one = power_request_pin_i
                         && (rail_enable_q[`BUCK_ONE_ON_BIT]
                             || seq_buck_one);
    rail_on_d.buck_two = power_request_pin_i
                         && (rail_enable_q[`BUCK_TWO_ON_BIT]
                             || seq_buck_two);
    rail_on_d.buck_three = power_request_pin_i
                           && (rail_enable_q[`BUCK_THREE_ON_BIT]
                               || seq_buck_three);
    rail_on_d.linreg_one = rail_enable_q[`LINREG_ONE_ON_BIT]
                           || seq_linreg_one;
    rail_on_d.linreg_two = rail_enable_q[`LINREG_TWO_ON_BIT];
    rail_on_d.system_power_rail =
      linreg_one_slot_q == `LINREG_SLOT_WITH_SYSTEM
      && slot == `SLOT_LAST;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rail_on_q <= '0;
      lockout_sel_q <= 2'(`LOCKOUT_THRESHOLD_RST);
    end else begin
      rail_on_q <= rail_on_d;
      lockout_sel_q <= lockout_threshold_q[1:0];
    end
  end

  assign rail_on_o = rail_on_q;
  assign reg_rdata_o = reg_rdata_q;
  assign lockout_threshold_sel_o = lockout_sel_q;

  // ==========================================================
  // checks
  sequence enable_write_s;
    wr_ok && reg_req_i.addr == `RAIL_ENABLE_OFS;
  endsequence

  sequence enable_read_s;
    reg_req_i.rd && reg_req_i.addr == `RAIL_ENABLE_OFS;
  endsequence

  enable_write_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    enable_write_s ##1 !(wr_ok && reg_req_i.addr == `RAIL_ENABLE_OFS)
      ##1 enable_read_s
      |=> reg_rdata_o == {1'b0, $past(reg_req_i.wdata[6:0], 3)})
    else $error("enable write not read back");

  enable_reserved_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    enable_read_s |=> reg_rdata_o[7] == 1'b0)
    else $error("enable bit 7 not zero");

  locked_write_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    reg_req_i.wr && !write_unlocked_i |=> $stable(rail_enable_q)
      && $stable(lockout_threshold_q) && $stable(linreg_one_slot_q)
      && $stable(buck_one_slot_q) && $stable(buck_two_slot_q)
      && $stable(buck_three_slot_q))
    else $error("locked write changed a register");

  lockout_reserved_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    reg_req_i.rd && reg_req_i.addr == `LOCKOUT_THRESHOLD_OFS
      |=> reg_rdata_o[7:3] == 5'h00)
    else $error("lockout reserved bits not zero");

  lockout_follow_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_ok && reg_req_i.addr == `LOCKOUT_THRESHOLD_OFS
      |=> ##1 lockout_threshold_sel_o == $past(reg_req_i.wdata[1:0], 2))
    else $error("threshold select not updated");

  switch_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    !power_request_pin_i |=> !rail_on_o.switch_one && !rail_on_o.switch_two
      && !rail_on_o.buck_one && !rail_on_o.buck_two && !rail_on_o.buck_three)
    else $error("gated rail on without request");

  linreg_two_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    1'b1 |=> rail_on_o.linreg_two == $past(rail_enable_q[0]))
    else $error("linreg two not following its bit");

  seq_buck_one_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    power_request_pin_i && buck_one_slot_q != 3'h0
      && slot == {1'b0, buck_one_slot_q} |=> rail_on_o.buck_one)
    else $error("buck one missed its slot");

  seq_excluded_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    buck_two_slot_q == 3'h0 && !rail_enable_q[`BUCK_TWO_ON_BIT]
      |=> !rail_on_o.buck_two)
    else $error("excluded buck two switched on");

  linreg_off_code_a: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (linreg_one_slot_q == 4'h8 || linreg_one_slot_q == 4'h9)
      && !rail_enable_q[`LINREG_ONE_ON_BIT] |=> !rail_on_o.linreg_one)
    else $error("linreg one on with off code");

endmodule : rail_enable_sequencer_regs

//--- verif/host_model.sv
// ==========================================================
// host side of the register port
module host_model (
  // clock
  input wire logic core_clk_i,
  // register port
  output rail_pkg::reg_req_t reg_req_o,
  output logic write_unlocked_o,
  input wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_req_o = '0;
    write_unlocked_o = 1'b0;
  end

  // one write; unlock marks the protected procedure as done
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           input logic unlock);
    @(posedge core_clk_i);
    #1;
    write_unlocked_o = unlock;
    reg_req_o.wr = 1'b1;
    reg_req_o.addr = a;
    reg_req_o.wdata = d;
    @(posedge core_clk_i);
    #1;
    reg_req_o.wr = 1'b0;
    reg_req_o.wdata = ~d;
    write_unlocked_o = 1'b0;
  endtask : write_reg

  // one read; data is taken the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    reg_req_o.rd = 1'b1;
    reg_req_o.addr = a;
    @(posedge core_clk_i);
    #1;
    reg_req_o.rd = 1'b0;
    d = reg_rdata_i;
  endtask : read_reg
endmodule : host_model

//--- verif/test_rail_enable_sequencer_regs.sv
// ==========================================================
// bench for the rail enable register bank
module test_rail_enable_sequencer_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic power_request_pin_i = 1'b0;
  rail_pkg::reg_req_t reg_req;
  logic write_unlocked;
  logic [7:0] reg_rdata_o;
  rail_pkg::rail_on_t rail_on_o;
  logic [1:0] lockout_threshold_sel_o;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  rail_enable_sequencer_regs rail_enable_sequencer_regs_inst (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .reg_req_i(reg_req),
    .write_unlocked_i(write_unlocked),
    .reg_rdata_o(reg_rdata_o),
    .power_request_pin_i(power_request_pin_i),
    .rail_on_o(rail_on_o),
    .lockout_threshold_sel_o(lockout_threshold_sel_o)
  );

  host_model host_model_inst (
    .core_clk_i(core_clk_i),
    .reg_req_o(reg_req),
    .write_unlocked_o(write_unlocked),
    .reg_rdata_i(reg_rdata_o)
  );

  // ==========================================================
  // checking helpers
  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_inst.read_reg(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.write_reg(a, d, 1'b1);
  endtask : wr

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wait_cyc

  task automatic set_pin(input logic v);
    @(posedge core_clk_i);
    #1;
    power_request_pin_i = v;
  endtask : set_pin

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // scenarios
  task automatic reset_values();
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h18, 8'h03);
    check("sel", {6'h00, lockout_threshold_sel_o}, 8'h03);
    rd_chk(8'h19, 8'h15);
    rd_chk(8'h1A, 8'h5F);
    check("rails", rail_on_o, 8'h00);
  endtask : reset_values

  task automatic locked_write();
    host_model_inst.write_reg(8'h16, 8'hFF, 1'b0);
    rd_chk(8'h16, 8'h00);
    host_model_inst.write_reg(8'h19, 8'h00, 1'b0);
    rd_chk(8'h19, 8'h15);
  endtask : locked_write

  task automatic reserved_bits();
    wr(8'h16, 8'hFF);
    rd_chk(8'h16, 8'h7F);
    wr(8'h16, 8'h00);
    wr(8'h18, 8'hFF);
    rd_chk(8'h18, 8'h07);
    wr(8'h19, 8'hFF);
    rd_chk(8'h19, 8'h77);
    wr(8'h1A, 8'hFF);
    rd_chk(8'h1A, 8'h7F);
    rd_chk(8'h17, 8'h00);
  endtask : reserved_bits

  task automatic lockout_codes();
    for (int c = 0; c < 4; c++) begin
      wr(8'h18, 8'hF8 | 8'(c));
      rd_chk(8'h18, 8'(c));
      check("sel", {6'h00, lockout_threshold_sel_o}, 8'(c));
    end
  endtask : lockout_codes

  task automatic direct_enables();
    wr(8'h19, 8'h00);
    wr(8'h1A, 8'h00);
    wr(8'h16, 8'h7F);
    wait_cyc(2);
    check("rails pin low", rail_on_o, 8'h06);
    set_pin(1'b1);
    wait_cyc(2);
    check("rails pin high", rail_on_o, 8'hFE);
    wr(8'h16, 8'h41);
    wait_cyc(1);
    check("rails partial", rail_on_o, 8'h82);
    wr(8'h16, 8'h00);
    wait_cyc(1);
    check("rails off", rail_on_o, 8'h00);
    set_pin(1'b0);
    wait_cyc(2);
  endtask : direct_enables

  task automatic sequencer_run();
    wr(8'h19, 8'h12);
    wr(8'h1A, 8'h0F);
    set_pin(1'b1);
    wait_cyc(50);
    check("slot one", rail_on_o, 8'h20);
    wait_cyc(200);
    check("slot two", rail_on_o, 8'h30);
    wait_cyc(2450);
    check("slot fourteen", rail_on_o, 8'h30);
    wait_cyc(300);
    check("slot fifteen", rail_on_o, 8'h35);
    wr(8'h1A, 8'h0E);
    wait_cyc(2);
    check("code fourteen", rail_on_o, 8'h34);
    wr(8'h1A, 8'h08);
    wait_cyc(2);
    check("code eight", rail_on_o, 8'h30);
    set_pin(1'b0);
    wait_cyc(2);
    check("pin dropped", rail_on_o, 8'h00);
  endtask : sequencer_run

  // reset again in mid run, every register back to its reset value
  task automatic mid_reset();
    wr(8'h16, 8'h7F);
    wr(8'h18, 8'h00);
    @(posedge core_clk_i);
    #1;
    rstn_i = 1'b0;
    wait_cyc(10);
    rstn_i = 1'b1;
    reset_values();
  endtask : mid_reset

  // ==========================================================
  // timeout and main sequence
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    wait_cyc(10);
    rstn_i = 1'b1;
    reset_values();
    locked_write();
    reserved_bits();
    lockout_codes();
    direct_enables();
    sequencer_run();
    mid_reset();
    close_out();
  end
endmodule : test_rail_enable_sequencer_regs
